// [hdl/dl3_pkg.sv]
// Shared constants and types for the third data-link HDLC control block
package dl3_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [11:0] SS7_MIN_FLAG_IDX  = 12'h0152;
  localparam logic [11:0] DL3_CONTROL_IDX   = 12'h0153;
  localparam logic [11:0] SS7_MODE_IDX      = 12'h0154;
  localparam logic [11:0] DL3_STATUS_IDX    = 12'h0155;
  localparam logic [7:0]  SS7_MIN_FLAG_RST  = 8'h05;
  localparam logic [7:0]  DL3_CONTROL_RST   = 8'h00;

  // Control field positions
  localparam int CTRL_LOOP_LINK_POS  = 7;
  localparam int CTRL_AUTO_ABORT_POS = 6;
  localparam int CTRL_RX_FCS_POS     = 5;
  localparam int CTRL_RX_DUP_POS     = 4;
  localparam int CTRL_TX_ABORT_POS   = 3;
  localparam int CTRL_TX_IDLE_POS    = 2;
  localparam int CTRL_TX_FCS_POS     = 1;
  localparam int CTRL_KIND_POS       = 0;

  // ****************************************************************
  // Link constants
  // ****************************************************************
  localparam logic [7:0]  FLAG_OCTET      = 8'h7E;
  localparam logic [7:0]  AUTO_ABORT_OCT  = 8'h7F;
  localparam logic [7:0]  FORCE_ABORT_OCT = 8'hFF;
  localparam logic [7:0]  BIT_WORD_LEAD   = 8'hFF;
  localparam logic [2:0]  STUFF_ONES      = 3'h5;
  localparam logic [15:0] FCS_INIT        = 16'hFFFF;
  localparam logic [15:0] FCS_RESIDUE     = 16'hF0B8;
  localparam logic [15:0] FCS_POLY_REV    = 16'h8408;
  localparam int          HOLD_DEPTH      = 16;

  // Framing formats
  localparam logic [1:0] FMT_SUPER    = 2'h0;
  localparam logic [1:0] FMT_EXTENDED = 2'h1;
  localparam logic [1:0] FMT_LOOP     = 2'h2;

  typedef enum logic [2:0] {
    TX_FLAG        = 3'b000,
    TX_MSG         = 3'b001,
    TX_ABORT_AUTO  = 3'b010,
    TX_ABORT_FORCE = 3'b011,
    TX_BIT_MSG     = 3'b100
  } tx_state_t;

  typedef struct packed {
    logic loop_link_enable;
    logic auto_abort_disable;
    logic rx_check_seq_disable;
    logic rx_duplicate_discard;
    logic tx_abort;
    logic tx_idle;
    logic tx_fcs_en;
    logic message_kind_select;
  } ctrl_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } tx_feed_t;

  typedef struct packed {
    logic       valid;
    logic       start;
    logic       last;
    logic       is_bit_msg;
    logic [7:0] data;
  } rx_byte_t;

  typedef struct packed {
    logic frame_ok;
    logic fcs_error;
    logic dup_drop;
  } rx_result_t;

  function automatic logic [31:0] reg_addr(input logic [11:0] idx);
    return {18'h0_0000, idx, 2'b00};
  endfunction

  function automatic logic [15:0] fcs_step(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ d[i]) begin
        c = (c >> 1) ^ FCS_POLY_REV;
      end else begin
        c = c >> 1;
      end
    end
    return c;
  endfunction

endpackage

// [hdl/dl3_rx_check.sv]
// Receive check-sequence verification and duplicate-message discard
`timescale 1ns/10ps
module dl3_rx_check
  import dl3_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Configuration
  input  wire logic       fcs_disable,
  input  wire logic       dup_discard,
  // Byte stream and result
  input  wire rx_byte_t   rx_in,
  output rx_result_t      result
);

  typedef struct packed {
    logic [HOLD_DEPTH-1:0][7:0] held;
    logic [HOLD_DEPTH-1:0][7:0] fresh;
    logic [7:0]                 held_len;
    logic                       held_valid;
    logic [7:0]                 len;
    logic                       differ;
    logic [15:0]                crc;
    rx_result_t                 res;
  } chk_state_t;

  chk_state_t st_ff;
  chk_state_t nxt_st;

  always_comb begin
    logic [7:0]  l;
    logic [15:0] c;
    logic        d;
    logic        fcs_ok;
    logic        dup;
    l = st_ff.len;
    c = st_ff.crc;
    d = st_ff.differ;
    fcs_ok = 1'b0;
    dup = 1'b0;
    nxt_st = st_ff;
    nxt_st.res = '0;
    if (rx_in.valid) begin
      if (rx_in.start) begin
        l = 8'h00;
        c = FCS_INIT;
        d = 1'b0;
      end
      c = fcs_step(c, rx_in.data);
      if (l < 8'(HOLD_DEPTH)) begin
        nxt_st.fresh[l[3:0]] = rx_in.data;
        if (st_ff.held[l[3:0]] != rx_in.data) begin
          d = 1'b1;
        end
      end
      if (l != 8'hFF) begin
        l = l + 8'h01;
      end
      if (rx_in.last) begin
        fcs_ok = rx_in.is_bit_msg || fcs_disable || (c == FCS_RESIDUE);
        dup = st_ff.held_valid && !d && (l == st_ff.held_len) && (l <= 8'(HOLD_DEPTH));
        if (!fcs_ok) begin
          nxt_st.res.fcs_error = 1'b1;
        end else if (dup && dup_discard) begin
          nxt_st.res.dup_drop = 1'b1;
        end else begin
          nxt_st.res.frame_ok = 1'b1;
          nxt_st.held = nxt_st.fresh;
          nxt_st.held_len = l;
          nxt_st.held_valid = 1'b1;
        end
      end
    end
    nxt_st.len = l;
    nxt_st.crc = c;
    nxt_st.differ = d;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign result = st_ff.res;

endmodule

// [hdl/dl3_ctrl.sv]
// Third data-link HDLC controller: registers, transmit engine, receive checks
//
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/10ps
module dl3_ctrl
  import dl3_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Framer side
  input  wire logic [1:0]  framing_format,
  output logic             loop_link_active,
  // Transmit data link
  input  wire logic        tx_bit_strobe,
  input  wire tx_feed_t    tx_feed,
  output logic             tx_feed_ready,
  input  wire logic [5:0]  bit_msg_code,
  output logic             tx_dl_bit,
  // Receive data link
  input  wire rx_byte_t    rx_in,
  output rx_result_t       rx_result
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic        ph_valid;
    logic        ph_write;
    logic [31:0] ph_addr;
    logic        rd_wait;
    logic [31:0] rdata;
    logic [7:0]  min_flags;
    ctrl_t       ctrl;
    logic        ss7_mode;
    logic        loop_active;
    tx_state_t   tx_state;
    logic [15:0] shreg;
    logic [3:0]  bit_cnt;
    logic [3:0]  bit_last;
    // Run of message ones, carried across octets
    logic [2:0]  ones;
    logic        msg_last;
    logic [7:0]  flag_cnt;
    logic        tx_bit;
  } blk_state_t;

  blk_state_t st_ff;
  blk_state_t nxt_st;
  logic       feed_take;

  // ****************************************************************
  // Register read mux
  // ****************************************************************
  function automatic logic [31:0] read_reg(input blk_state_t s, input logic [31:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    if (a == reg_addr(SS7_MIN_FLAG_IDX)) begin
      v = {24'h00_0000, s.min_flags};
    end else if (a == reg_addr(DL3_CONTROL_IDX)) begin
      v = {24'h00_0000, s.ctrl};
    end else if (a == reg_addr(SS7_MODE_IDX)) begin
      v = {31'h0000_0000, s.ss7_mode};
    end else if (a == reg_addr(DL3_STATUS_IDX)) begin
      v = {16'h0000, s.flag_cnt, 4'h0, s.loop_active, s.tx_state};
    end
    return v;
  endfunction

  // Flags needed after a closing flag or an abort
  function automatic logic [7:0] need_flags(input logic ss7, input logic [7:0] m);
    logic [7:0] n;
    n = 8'h01;
    if (ss7 && (m > 8'h01)) begin
      n = m;
    end
    return n;
  endfunction

  function automatic logic [15:0] bit_word(input logic [5:0] code);
    return {BIT_WORD_LEAD, 1'b0, code, 1'b0};
  endfunction

  function automatic ctrl_t ctrl_decode(input logic [7:0] w);
    ctrl_t c;
    c.loop_link_enable     = w[CTRL_LOOP_LINK_POS];
    c.auto_abort_disable   = w[CTRL_AUTO_ABORT_POS];
    c.rx_check_seq_disable = w[CTRL_RX_FCS_POS];
    c.rx_duplicate_discard = w[CTRL_RX_DUP_POS];
    c.tx_abort             = w[CTRL_TX_ABORT_POS];
    c.tx_idle              = w[CTRL_TX_IDLE_POS];
    c.tx_fcs_en            = w[CTRL_TX_FCS_POS];
    c.message_kind_select  = w[CTRL_KIND_POS];
    return c;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic        bit_o;
    logic        done;
    logic        take;
    logic [7:0]  fc;
    logic [7:0]  wd;
    nxt_st = st_ff;
    bit_o = st_ff.tx_bit;
    done = 1'b0;
    take = 1'b0;
    fc = st_ff.flag_cnt;
    wd = hwdata[7:0];

    // Bus address phase
    // Reads fetch their data in the one wait cycle
    if (hready) begin
      nxt_st.ph_valid = hsel && htrans[1];
      nxt_st.ph_write = hwrite;
      nxt_st.ph_addr = haddr;
      nxt_st.rd_wait = hsel && htrans[1] && !hwrite;
    end else if (st_ff.rd_wait) begin
      nxt_st.rd_wait = 1'b0;
      nxt_st.rdata = read_reg(st_ff, st_ff.ph_addr);
    end

    // Bus write data phase
    if (st_ff.ph_valid && st_ff.ph_write && hready) begin
      if (st_ff.ph_addr == reg_addr(SS7_MIN_FLAG_IDX)) begin
        nxt_st.min_flags = wd;
      end else if (st_ff.ph_addr == reg_addr(DL3_CONTROL_IDX)) begin
        nxt_st.ctrl = ctrl_decode(wd);
      end else if (st_ff.ph_addr == reg_addr(SS7_MODE_IDX)) begin
        nxt_st.ss7_mode = wd[0];
      end
    end

    // Loop-carrier link gating
    nxt_st.loop_active = st_ff.ctrl.loop_link_enable &&
                         ((framing_format == FMT_LOOP) ||
                          (framing_format == FMT_EXTENDED));

    // Serial transmit
    if (tx_bit_strobe) begin
      // Zero after five ones, also ahead of the closing flag
      if (st_ff.ones == STUFF_ONES) begin
        bit_o = 1'b0;
        nxt_st.ones = 3'h0;
      end else begin
        bit_o = st_ff.shreg[15];
        nxt_st.shreg = {st_ff.shreg[14:0], 1'b0};
        nxt_st.bit_cnt = st_ff.bit_cnt + 4'h1;
        if (st_ff.tx_state == TX_MSG && bit_o) begin
          nxt_st.ones = st_ff.ones + 3'h1;
        end else begin
          nxt_st.ones = 3'h0;
        end
        done = (st_ff.bit_cnt == st_ff.bit_last);
      end
    end
    nxt_st.tx_bit = bit_o;

    // Unit boundary: kind and abort changes act only here
    if (done) begin
      nxt_st.bit_cnt = 4'h0;
      nxt_st.bit_last = 4'h7;
      if (st_ff.ctrl.tx_abort) begin
        nxt_st.ones = 3'h0;
        nxt_st.tx_state = TX_ABORT_FORCE;
        nxt_st.shreg = {FORCE_ABORT_OCT, 8'h00};
      end else begin
        unique case (st_ff.tx_state)
          TX_MSG: begin
            if (!st_ff.ctrl.message_kind_select) begin
              nxt_st.ones = 3'h0;
              if (!st_ff.ctrl.auto_abort_disable) begin
                nxt_st.tx_state = TX_ABORT_AUTO;
                nxt_st.shreg = {AUTO_ABORT_OCT, 8'h00};
              end else begin
                nxt_st.tx_state = TX_BIT_MSG;
                nxt_st.shreg = bit_word(bit_msg_code);
                nxt_st.bit_last = 4'hF;
              end
            end else if (st_ff.msg_last) begin
              nxt_st.tx_state = TX_FLAG;
              nxt_st.shreg = {FLAG_OCTET, 8'h00};
              fc = 8'h00;
            end else if (tx_feed.valid) begin
              take = 1'b1;
              nxt_st.shreg = {tx_feed.data, 8'h00};
              nxt_st.msg_last = tx_feed.last;
            end else begin
              // Missing byte mid-message cuts it with an abort
              nxt_st.ones = 3'h0;
              nxt_st.tx_state = TX_ABORT_AUTO;
              nxt_st.shreg = {AUTO_ABORT_OCT, 8'h00};
            end
          end
          TX_FLAG: begin
            if (fc != 8'hFF) begin
              fc = fc + 8'h01;
            end
            // Bit-oriented kind wins over a waiting message
            if (!st_ff.ctrl.message_kind_select) begin
              nxt_st.tx_state = TX_BIT_MSG;
              nxt_st.shreg = bit_word(bit_msg_code);
              nxt_st.bit_last = 4'hF;
            end else if (tx_feed.valid && !st_ff.ctrl.tx_idle &&
                         (fc >= need_flags(st_ff.ss7_mode, st_ff.min_flags))) begin
              take = 1'b1;
              nxt_st.tx_state = TX_MSG;
              nxt_st.shreg = {tx_feed.data, 8'h00};
              nxt_st.msg_last = tx_feed.last;
            end else begin
              nxt_st.shreg = {FLAG_OCTET, 8'h00};
            end
          end
          TX_ABORT_AUTO, TX_ABORT_FORCE: begin
            nxt_st.tx_state = TX_FLAG;
            nxt_st.shreg = {FLAG_OCTET, 8'h00};
            fc = 8'h00;
          end
          TX_BIT_MSG: begin
            if (st_ff.ctrl.message_kind_select) begin
              nxt_st.tx_state = TX_FLAG;
              nxt_st.shreg = {FLAG_OCTET, 8'h00};
              fc = 8'h00;
            end else begin
              nxt_st.shreg = bit_word(bit_msg_code);
              nxt_st.bit_last = 4'hF;
            end
          end
          default: begin
            nxt_st.tx_state = TX_FLAG;
            nxt_st.shreg = {FLAG_OCTET, 8'h00};
          end
        endcase
      end
    end
    nxt_st.flag_cnt = fc;
    feed_take = take;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.min_flags <= SS7_MIN_FLAG_RST;
      st_ff.ctrl <= ctrl_t'(DL3_CONTROL_RST);
      // Transmitter sends one flag from reset, then repeats the bit-oriented message
      st_ff.tx_state <= TX_FLAG;
      st_ff.shreg <= {FLAG_OCTET, 8'h00};
      st_ff.bit_last <= 4'h7;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************************************
  // Receive checks
  // ****************************************************************
  // Receive side is not gated by the link enable
  dl3_rx_check u_rx_check (
    .clk         (clk),
    .rst         (rst),
    .fcs_disable (st_ff.ctrl.rx_check_seq_disable),
    .dup_discard (st_ff.ctrl.rx_duplicate_discard),
    .rx_in       (rx_in),
    .result      (rx_result)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign hreadyout        = !st_ff.rd_wait;
  assign hrdata           = st_ff.rdata;
  assign hresp            = 1'b0;
  assign loop_link_active = st_ff.loop_active;
  assign tx_feed_ready    = feed_take;
  assign tx_dl_bit        = st_ff.tx_bit;

endmodule

// [testbench/dl3_ctrl_props.sv]
// Concurrent checks on the data-link control block ports
`timescale 1ns/10ps
module dl3_ctrl_props
  import dl3_pkg::*;
(
  // Clock and bus
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  // Link side
  input wire logic [1:0]  framing_format,
  input wire logic        loop_link_active,
  input wire logic        tx_bit_strobe,
  input wire logic        tx_feed_ready,
  input wire logic        tx_dl_bit,
  input wire rx_byte_t    rx_in,
  input wire rx_result_t  rx_result
);
  logic [7:0] ctl_ff;
  logic       wph_ff;
  logic [5:0] age_ff;
  logic       fmt_ok;
  assign fmt_ok = (framing_format == 2'h1) || (framing_format == 2'h2);
  // Shadow of control register, strobes since last write
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_ff <= 8'h00;
      wph_ff <= 1'b0;
      age_ff <= 6'h00;
    end else begin
      if (hready) begin
        wph_ff <= hsel && htrans[1] && hwrite && (haddr == 32'h0000_054C);
      end
      if (wph_ff && hready) begin
        ctl_ff <= hwdata[7:0];
        age_ff <= 6'h00;
      end else if (tx_bit_strobe && (age_ff != 6'h3F)) begin
        age_ff <= age_ff + 6'h01;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_last;
    rx_in.valid && rx_in.last;
  endsequence
  property p_link_on;
    ctl_ff[7] && fmt_ok |=> loop_link_active;
  endproperty
  property p_link_off;
    !(ctl_ff[7] && fmt_ok) |=> !loop_link_active;
  endproperty
  property p_fcs_off;
    s_last ##0 ctl_ff[5] |=> !rx_result.fcs_error;
  endproperty
  property p_dup_off;
    s_last ##0 !ctl_ff[4] |=> !rx_result.dup_drop;
  endproperty
  property p_verdict;
    s_last |=> $onehot(rx_result);
  endproperty
  property p_force;
    tx_bit_strobe && ctl_ff[3] && (age_ff > 6'd24) |=> tx_dl_bit;
  endproperty
  property p_abort_hold;
    ctl_ff[3] && (age_ff > 6'd24) |-> !tx_feed_ready;
  endproperty
  property p_bos_hold;
    !ctl_ff[0] && (age_ff > 6'd24) |-> !tx_feed_ready;
  endproperty
  a_link_on: assert property (p_link_on)
    else $error("link active missing");
  a_link_off: assert property (p_link_off)
    else $error("link active wrongly set");
  a_fcs_off: assert property (p_fcs_off)
    else $error("check error with check disabled");
  a_dup_off: assert property (p_dup_off)
    else $error("drop with discard disabled");
  a_verdict: assert property (p_verdict)
    else $error("frame verdict not one-hot");
  a_force: assert property (p_force)
    else $error("zero sent during forced abort");
  a_abort_hold: assert property (p_abort_hold)
    else $error("byte taken during forced abort");
  a_bos_hold: assert property (p_bos_hold)
    else $error("byte taken in bit-oriented mode");
endmodule

bind dl3_ctrl dl3_ctrl_props chk (
  .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .framing_format(framing_format), .loop_link_active(loop_link_active),
  .tx_bit_strobe(tx_bit_strobe), .tx_feed_ready(tx_feed_ready),
  .tx_dl_bit(tx_dl_bit), .rx_in(rx_in), .rx_result(rx_result));

// [testbench/dl3_far_end.sv]
// Remote terminal model: bit slots, link capture, receive frames
`timescale 1ns/10ps
module dl3_far_end
  import dl3_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Link
  input  wire logic       tx_dl_bit,
  output logic            tx_bit_strobe,
  output rx_byte_t        rx_in,
  input  wire rx_result_t rx_result,
  output logic [15:0]     seen
);
  logic [1:0] div_ff;
  initial rx_in = '0;
  // One slot in four cycles, capture bit after its slot
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div_ff        <= 2'h0;
      tx_bit_strobe <= 1'b0;
      seen          <= 16'h0000;
    end else begin
      div_ff        <= div_ff + 2'h1;
      tx_bit_strobe <= (div_ff == 2'h3);
      if (div_ff == 2'h1) begin
        seen <= {seen[14:0], tx_dl_bit};
      end
    end
  end
  task automatic send(input logic [7:0] b0, input logic [7:0] b1, input logic bit_msg,
                      output rx_result_t res);
    @(posedge clk);
    rx_in <= '{1'b1, 1'b1, 1'b0, bit_msg, b0};
    @(posedge clk);
    rx_in <= '{1'b1, 1'b0, 1'b1, bit_msg, b1};
    @(posedge clk);
    rx_in <= '{1'b0, 1'b0, 1'b0, 1'b0, ~b1};
    @(negedge clk);
    res = rx_result;
    @(posedge clk);
  endtask
endmodule

// [testbench/dl3_ctrl_bench.sv]
// Self-checking bench for the data-link control block
`timescale 1ns/10ps
module dl3_ctrl_bench;
  import dl3_pkg::*;
  logic        clk, rst, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, framing_format;
  logic [2:0]  hsize;
  logic        loop_link_active, tx_bit_strobe, tx_feed_ready, tx_dl_bit, found;
  logic [5:0]  bit_msg_code;
  logic [15:0] seen;
  tx_feed_t    tx_feed;
  rx_byte_t    rx_in;
  rx_result_t  rx_result, res;
  int          err_count, comparisons, cycles, c;

  dl3_ctrl dut (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .framing_format(framing_format), .loop_link_active(loop_link_active),
    .tx_bit_strobe(tx_bit_strobe), .tx_feed(tx_feed), .tx_feed_ready(tx_feed_ready),
    .bit_msg_code(bit_msg_code), .tx_dl_bit(tx_dl_bit), .rx_in(rx_in), .rx_result(rx_result));
  dl3_far_end far (.clk(clk), .rst(rst), .tx_dl_bit(tx_dl_bit),
    .tx_bit_strobe(tx_bit_strobe), .rx_in(rx_in), .rx_result(rx_result), .seen(seen));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    logic r;
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {18'h0_0000, idx, 2'b00};
    do begin
      @(negedge clk);
      r = hreadyout;
      @(posedge clk);
    end while (r !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do begin
      @(negedge clk);
      r  = hreadyout;
      rd = hrdata;
      @(posedge clk);
    end while (r !== 1'b1);
  endtask
  task automatic rdc(input logic [11:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0000_0000);
    chk(rd, exp);
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask
  task automatic find(input logic [15:0] pat, input logic [15:0] mask, input int n,
                      input logic exp);
    found = 1'b0;
    repeat (n) begin
      @(negedge clk);
      if ((seen & mask) === pat) found = 1'b1;
    end
    @(posedge clk);
    chk({31'h0, found}, {31'h0, exp});
  endtask
  task automatic gap;
    do @(negedge clk); while (tx_feed_ready !== 1'b1);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (tx_feed_ready !== 1'b1);
    @(posedge clk);
  endtask
  task automatic rxc(input logic [7:0] ctl, input logic [7:0] b1, input logic bit_msg,
                     input logic [2:0] exp);
    bus(1'b1, DL3_CONTROL_IDX, {24'h00_0000, ctl});
    far.send(8'h00, b1, bit_msg, res);
    chk({29'h0, res}, {29'h0, exp});
  endtask
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      $display("mismatch at %0t: timeout", $time);
      give_verdict();
    end
  end
  initial begin
    {rst, hsel, haddr, htrans, hwrite, hwdata, framing_format} = '1;
    {hsel, haddr, htrans, hwrite, hwdata, framing_format} = '0;
    {err_count, comparisons, cycles} = '0;
    hsize    = 3'h2;
    tx_feed  = '0;
    bit_msg_code = 6'h15;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rdc(SS7_MIN_FLAG_IDX, 32'h0000_0005);
    rdc(DL3_CONTROL_IDX, 32'h0000_0000);
    bus(1'b1, SS7_MIN_FLAG_IDX, 32'h0000_00A3);
    rdc(SS7_MIN_FLAG_IDX, 32'h0000_00A3);
    rdc(12'h0160, 32'h0000_0000);
    $display("test registers done");
    for (int f = 0; f < 4; f++) begin
      framing_format <= f[1:0];
      bus(1'b1, DL3_CONTROL_IDX, 32'h0000_0081);
      repeat (2) @(negedge clk);
      chk({31'h0, loop_link_active}, {31'h0, (f == 1 || f == 2)});
      @(posedge clk);
    end
    bus(1'b1, DL3_CONTROL_IDX, 32'h0000_0001);
    repeat (2) @(negedge clk);
    chk({31'h0, loop_link_active}, 32'h0000_0000);
    @(posedge clk);
    $display("test loop link done");
    find(16'h007E, 16'h00FF, 200, 1'b1);
    bus(1'b1, DL3_CONTROL_IDX, 32'h0000_0009);
    find(16'hFFFF, 16'hFFFF, 200, 1'b1);
    bus(1'b1, DL3_CONTROL_IDX, 32'h0000_0001);
    find(16'h007E, 16'h00FF, 200, 1'b1);
    bus(1'b1, DL3_CONTROL_IDX, 32'h0000_0000);
    find(16'hFF2A, 16'hFFFF, 300, 1'b1);
    $display("test transmit idle abort done");
    tx_feed <= '{1'b1, 1'b0, 8'h00};
    for (int a = 0; a < 2; a++) begin
      bus(1'b1, DL3_CONTROL_IDX, 32'h0000_0001 | (a << 6));
      repeat (200) @(posedge clk);
      bus(1'b1, DL3_CONTROL_IDX, 32'h0000_0000 | (a << 6));
      find(16'h7F7E, 16'hFFFF, 300, a == 0);
    end
    $display("test auto abort done");
    tx_feed <= '{1'b1, 1'b1, 8'h00};
    bus(1'b1, SS7_MODE_IDX, 32'h0000_0001);
    bus(1'b1, DL3_CONTROL_IDX, 32'h0000_0001);
    for (int n = 2; n < 8; n += 4) begin
      bus(1'b1, SS7_MIN_FLAG_IDX, n);
      gap();
      gap();
      chk({31'h0, c >= (n + 1) * 32}, 32'h0000_0001);
    end
    bus(1'b1, DL3_CONTROL_IDX, 32'h0000_0005);
    repeat (100) @(posedge clk);
    found = 1'b0;
    repeat (300) begin
      @(negedge clk);
      if (tx_feed_ready === 1'b1) found = 1'b1;
    end
    @(posedge clk);
    chk({31'h0, found}, 32'h0000_0000);
    tx_feed <= '0;
    $display("test flag spacing done");
    rxc(8'h01, 8'h00, 1'b0, 3'b100);
    rxc(8'h01, 8'h01, 1'b0, 3'b010);
    rxc(8'h21, 8'h01, 1'b0, 3'b100);
    rxc(8'h31, 8'h01, 1'b0, 3'b001);
    rxc(8'h21, 8'h01, 1'b0, 3'b100);
    rxc(8'h11, 8'h55, 1'b1, 3'b100);
    rxc(8'h11, 8'h55, 1'b1, 3'b001);
    $display("test receive checks done");
    give_verdict();
  end
endmodule
